// ---- rtl/fsk_map.svh ----
`ifndef FSK_MAP_SVH
`define FSK_MAP_SVH
// Register byte addresses
`define ADDR_DEMOD_SETUP   8'h00
`define ADDR_SYNC_SETUP    8'h04
`define ADDR_SYNC_WORD     8'h08
`define ADDR_STATUS        8'h0C
`define ADDR_AVERAGE       8'h10
// Demodulator setup fields
`define DS_SEL_LO          4
`define DS_SEL_HI          5
`define DS_BW_LO           6
`define DS_BW_HI           15
`define DS_MODE_LO         23
`define DS_MODE_HI         25
// Sync setup fields
`define SS_LEN_LO          4
`define SS_LEN_HI          5
`define SS_TOL_LO          6
`define SS_TOL_HI          7
// Field values
`define SEL_LINEAR         2'h0
`define MODE_SYNC_A        3'h2
`define MODE_SYNC_B        3'h3
// Status bit positions
`define ST_LOCK            0
`define ST_OVERFLOW        1
`define ST_SLICE           2
`define ST_RX              3
// Reset values
`define DEMOD_SETUP_RST    32'h0000_0000
`define SYNC_SETUP_RST     32'h0000_0000
`define SYNC_WORD_RST      24'h00_0000
// Timing and scaling
`define OVS_PER_BIT        32
`define OVS_MID            5'h10
`define OVS_LAST           5'h1F
`define LOCK_DCLK_CYCLES   4'h9
`define LEN_BASE           5'h0C
`define LEN_STEP           5'h04
`define SYNC_WORD_BITS     5'h18
`define BW_FRAC_BITS       10
`define DISC_SCALE         12
`define ENV_DECAY_SHIFT    8
`endif

// ---- rtl/fsk_pkg.sv ----
package fsk_pkg;
	// Filter and envelope sample word
	typedef logic signed [15:0] sample_t;
	// Interrupt/lock output sequencing
	typedef enum logic [0:0] {LK_IDLE, LK_HOLD} lock_state_t;
endpackage

// ---- rtl/two_entry_buffer.sv ----
`timescale 1ns/100ps
module two_entry_buffer #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,     // System clock
	input  wire logic             rst_n_i,   // Sync reset, active low
	input  wire logic             in_valid_i, // Word offered
	output logic                  in_ready_o, // Room for a word
	input  wire logic [WIDTH-1:0] in_data_i,  // Incoming word
	output logic                  out_valid_o, // Word available
	input  wire logic             out_ready_i, // Receiver accepts
	output logic      [WIDTH-1:0] out_data_o   // Head word, registered
);
	logic [WIDTH-1:0] head_r, head_nxt, tail_r, tail_nxt;
	logic             hv_r, hv_nxt, tv_r, tv_nxt;

	// Full only when both slots hold a word
	assign in_ready_o  = !tv_r;
	assign out_valid_o = hv_r;
	assign out_data_o  = head_r;

	// Head drains first; tail catches a word that arrives during a stall
	always_comb begin
		head_nxt = head_r;
		tail_nxt = tail_r;
		hv_nxt   = hv_r;
		tv_nxt   = tv_r;
		if (hv_r && out_ready_i) begin
			hv_nxt   = tv_r;
			head_nxt = tail_r;
			tv_nxt   = 1'b0;
		end
		if (in_valid_i && !tv_r) begin
			if (!hv_nxt) begin
				hv_nxt   = 1'b1;
				head_nxt = in_data_i;
			end else begin
				tv_nxt   = 1'b1;
				tail_nxt = in_data_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			head_r <= '0;
			tail_r <= '0;
			hv_r   <= 1'b0;
			tv_r   <= 1'b0;
		end else begin
			head_r <= head_nxt;
			tail_r <= tail_nxt;
			hv_r   <= hv_nxt;
			tv_r   <= tv_nxt;
		end
	end
endmodule

// ---- rtl/fsk_sync_word_detector.sv ----
// Operation
// RQ1 - The linear demodulation path runs only when the demodulator select field is 00.
// RQ2 - The discriminator gives a value proportional to the frequency of the limited input.
// RQ3 - The discriminator value is averaged, envelope tracked, and sliced against a threshold.
// RQ4 - In linear mode the slicer bit drives the clock recovery PLL.
// RQ5 - The averaging cutoff follows the ten-bit bandwidth setting scaled by two to the tenth.
// RQ6 - In receive mode the stored word is compared with the bit stream and a match raises lock.
// RQ7 - The lock output drops by itself after nine recovered data clock cycles.
// RQ8 - Word detection works only when the demodulator mode field is 010 or 011.
// RQ9 - The length field selects a compared word of 12, 16, 20 or 24 bits.
// RQ10 - The far transmitter sends the word most significant bit first.
// RQ11 - The tolerance field allows a match with up to three wrong bits.
// RQ12 - The host loads the expected word before relying on detection.
// RQ13 - Clock recovery oversamples at 32 times the data rate and tolerates 2 percent error.
// RQ14 - Length codes 00 to 11 map upward to 12, 16, 20 and 24 bits.
// RQ15 - The tolerance value equals the largest accepted count of wrong bits, zero to three.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "fsk_map.svh"
module fsk_sync_word_detector #(
	parameter int CLK_HZ  = 25000000, // Demodulator clock rate
	parameter int DATA_HZ = 38400     // Nominal bit rate
) (
	input  wire logic        CLK_I,        // 25 MHz clock
	input  wire logic        RST_N_I,      // Sync reset, active low
	input  wire logic        LIM_I_I,      // Limited in-phase sign, async pin
	input  wire logic        LIM_Q_I,      // Limited quadrature sign, async pin
	input  wire logic        RX_EN_I,      // Receive mode, async pin
	input  wire logic [7:0]  ADDR_I,       // Register byte address
	input  wire logic [31:0] WDATA_I,      // Write data
	input  wire logic        WR_I,         // Write strobe
	input  wire logic        RD_I,         // Read strobe
	output logic      [31:0] RDATA_O,      // Read data, cycle after strobe
	output logic             LOCK_O,       // Interrupt/lock, active high
	output logic             DCLK_O,       // Recovered data clock pulse
	output logic             DATA_O,       // Buffered recovered bit
	output logic             DATA_VALID_O, // Buffered bit valid
	input  wire logic        DATA_READY_I  // Receiver accepts bit
);
	import fsk_pkg::*;

	localparam int OVS_DIV = CLK_HZ / (DATA_HZ * `OVS_PER_BIT);
	localparam logic [15:0] OVS_DIV_M1 = 16'(OVS_DIV - 1);

	// Length code to word length
	// RQ14 ascending code map
	function automatic logic [4:0] word_len(input logic [1:0] code);
		word_len = 5'(`LEN_BASE + (`LEN_STEP * code));
	endfunction

	// Wrong bits among the low len positions
	function automatic logic [4:0] miss_count(input logic [23:0] a, input logic [23:0] b,
			input logic [4:0] len);
		logic [4:0] n;
		n = 5'h00;
		for (int k = 0; k < 24; k++) begin
			if ((5'(k) < len) && (a[k] != b[k])) begin
				n = n + 5'h01;
			end
		end
		miss_count = n;
	endfunction

	// Pin synchronisers: three stages, change taken when stages two and three agree
	logic [2:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
	always_comb begin
		pin_nxt = pin_r;
		for (int k = 0; k < 3; k++) begin
			if (s2_r[k] == s3_r[k]) begin
				pin_nxt[k] = s3_r[k];
			end
		end
	end
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			s1_r  <= 3'h0;
			s2_r  <= 3'h0;
			s3_r  <= 3'h0;
			pin_r <= 3'h0;
		end else begin
			s1_r  <= {RX_EN_I, LIM_Q_I, LIM_I_I};
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			pin_r <= pin_nxt;
		end
	end
	wire lim_i = pin_r[0];
	wire lim_q = pin_r[1];
	wire rx_en = pin_r[2];

	// Register file
	logic [31:0] demod_r, demod_nxt, sync_setup_r, sync_setup_nxt, rdata_r, rdata_nxt;
	logic [23:0] word_r, word_nxt;
	logic        ovf_r, ovf_nxt;
	logic        ovf_evt;
	sample_t     avg_r;
	logic        slice_r, lock_r;
	wire  [1:0]  dsel  = demod_r[`DS_SEL_HI:`DS_SEL_LO];
	wire  [9:0]  bw    = demod_r[`DS_BW_HI:`DS_BW_LO];
	wire  [2:0]  dmode = demod_r[`DS_MODE_HI:`DS_MODE_LO];
	wire  [1:0]  lcode = sync_setup_r[`SS_LEN_HI:`SS_LEN_LO];
	wire  [1:0]  tol   = sync_setup_r[`SS_TOL_HI:`SS_TOL_LO];
	always_comb begin
		demod_nxt      = demod_r;
		sync_setup_nxt = sync_setup_r;
		word_nxt       = word_r;
		ovf_nxt        = ovf_r;
		rdata_nxt      = 32'h0000_0000;
		if (WR_I) begin
			case (ADDR_I)
				`ADDR_DEMOD_SETUP: demod_nxt = WDATA_I;
				`ADDR_SYNC_SETUP: sync_setup_nxt = WDATA_I;
				// RQ12 host-loaded word
				`ADDR_SYNC_WORD: word_nxt = WDATA_I[23:0];
				`ADDR_STATUS: ovf_nxt = 1'b0;
				default: ;
			endcase
		end
		// Overflow set wins over a clear in the same cycle
		if (ovf_evt) begin
			ovf_nxt = 1'b1;
		end
		if (RD_I) begin
			case (ADDR_I)
				`ADDR_DEMOD_SETUP: rdata_nxt = demod_r;
				`ADDR_SYNC_SETUP: rdata_nxt = sync_setup_r;
				`ADDR_SYNC_WORD: rdata_nxt = {8'h00, word_r};
				`ADDR_STATUS: begin
					rdata_nxt[`ST_LOCK]     = lock_r;
					rdata_nxt[`ST_OVERFLOW] = ovf_r;
					rdata_nxt[`ST_SLICE]    = slice_r;
					rdata_nxt[`ST_RX]       = rx_en;
				end
				`ADDR_AVERAGE: rdata_nxt = {{16{avg_r[15]}}, avg_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			demod_r      <= `DEMOD_SETUP_RST;
			sync_setup_r <= `SYNC_SETUP_RST;
			word_r       <= `SYNC_WORD_RST;
			ovf_r        <= 1'b0;
			rdata_r      <= 32'h0000_0000;
		end else begin
			demod_r      <= demod_nxt;
			sync_setup_r <= sync_setup_nxt;
			word_r       <= word_nxt;
			ovf_r        <= ovf_nxt;
			rdata_r      <= rdata_nxt;
		end
	end
	assign RDATA_O = rdata_r;

	// Demodulator: quadrant step discriminator, IIR average, envelope, slicer
	wire linear_on = (dsel == `SEL_LINEAR);
	logic [1:0]   quad_r, quad_nxt;
	sample_t      avg_nxt, max_r, max_nxt, min_r, min_nxt;
	logic         slice_nxt;
	logic signed [1:0]  disc;
	logic signed [16:0] diff, thr;
	logic signed [27:0] prod;
	always_comb begin
		// Binary quadrant decoded from the Gray signs so one step per quarter turn; steps per sample track frequency
		quad_nxt = {lim_i, lim_i ^ lim_q};
		// RQ2 discriminator step
		case (2'(quad_nxt - quad_r))
			2'h1: disc = 2'sb01;
			2'h3: disc = -2'sb01;
			default: disc = 2'sb00;
		endcase
		// RQ5 coefficient is setting over two to the tenth
		diff = 17'((18'(disc) <<< `DISC_SCALE) - 18'(avg_r));
		prod = 28'(diff * $signed({1'b0, bw}));
		avg_nxt = 16'(17'(avg_r) + 17'(prod >>> `BW_FRAC_BITS));
		// RQ3 envelope peaks decay slowly so the threshold follows drift
		max_nxt = (avg_r > max_r) ? avg_r :
			16'(max_r - ((max_r - avg_r) >>> `ENV_DECAY_SHIFT));
		min_nxt = (avg_r < min_r) ? avg_r :
			16'(min_r + ((avg_r - min_r) >>> `ENV_DECAY_SHIFT));
		thr = (17'(max_r) + 17'(min_r)) >>> 1;
		// RQ3 threshold slicer
		slice_nxt = (17'(avg_r) > thr);
		// RQ1 other selects freeze the linear path
		if (!linear_on) begin
			avg_nxt   = avg_r;
			max_nxt   = max_r;
			min_nxt   = min_r;
			slice_nxt = slice_r;
		end
	end
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			quad_r  <= 2'h0;
			avg_r   <= 16'sh0000;
			max_r   <= 16'sh0000;
			min_r   <= 16'sh0000;
			slice_r <= 1'b0;
		end else begin
			quad_r  <= quad_nxt;
			avg_r   <= avg_nxt;
			max_r   <= max_nxt;
			min_r   <= min_nxt;
			slice_r <= slice_nxt;
		end
	end

	// Clock recovery: oversample divider and phase counter, nudged on bit edges
	logic [15:0] div_r, div_nxt;
	logic [4:0]  ph_r, ph_nxt;
	logic        last_r, last_nxt, tick, dclk_r, dclk_nxt, bit_r, bit_nxt;
	always_comb begin
		// RQ13 tick at 32 per bit
		tick    = (div_r == OVS_DIV_M1);
		div_nxt = tick ? 16'h0000 : 16'(div_r + 16'h0001);
		ph_nxt   = ph_r;
		last_nxt = last_r;
		dclk_nxt = 1'b0;
		bit_nxt  = bit_r;
		if (tick && linear_on) begin
			// RQ4 slicer edges steer the phase by one step, enough for a few percent error
			last_nxt = slice_r;
			ph_nxt   = 5'(ph_r + 5'h01);
			if (slice_r != last_r) begin
				if (ph_r > `OVS_MID) begin
					ph_nxt = 5'(ph_r + 5'h02);
				end else if ((ph_r < `OVS_MID) && (ph_r != 5'h00)) begin
					ph_nxt = ph_r;
				end
			end
			// Sample in mid bit
			if (ph_r == `OVS_MID) begin
				dclk_nxt = 1'b1;
				bit_nxt  = slice_r;
			end
		end
	end
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			div_r  <= 16'h0000;
			ph_r   <= 5'h00;
			last_r <= 1'b0;
			dclk_r <= 1'b0;
			bit_r  <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			ph_r   <= ph_nxt;
			last_r <= last_nxt;
			dclk_r <= dclk_nxt;
			bit_r  <= bit_nxt;
		end
	end
	assign DCLK_O = dclk_r;

	// Word detector and lock sequencing
	logic [23:0] sh_r, sh_nxt;
	logic [4:0]  seen_r, seen_nxt, len;
	logic [3:0]  cnt_r, cnt_nxt;
	lock_state_t lk_r, lk_nxt;
	logic        hit, det_on;
	always_comb begin
		// RQ9 length map
		len    = word_len(lcode);
		// RQ8 mode gate
		det_on = rx_en && ((dmode == `MODE_SYNC_A) || (dmode == `MODE_SYNC_B));
		sh_nxt   = sh_r;
		seen_nxt = det_on ? seen_r : 5'h00;
		hit      = 1'b0;
		if (dclk_r && det_on) begin
			// RQ10 first bit ends up at the top of the window
			sh_nxt = {sh_r[22:0], bit_r};
			if (seen_r != `SYNC_WORD_BITS) begin
				seen_nxt = 5'(seen_r + 5'h01);
			end
			// RQ11 RQ15 tolerance compare
			hit = (seen_nxt >= len) && (miss_count(sh_nxt, word_r, len) <= {3'h0, tol});
		end
		lk_nxt  = lk_r;
		cnt_nxt = cnt_r;
		case (lk_r)
			LK_IDLE: begin
				// RQ6 raise lock on match
				if (hit) begin
					lk_nxt  = LK_HOLD;
					cnt_nxt = 4'h0;
				end
			end
			LK_HOLD: begin
				// RQ7 release after nine data clocks, a new match restarts
				if (hit) begin
					cnt_nxt = 4'h0;
				end else if (dclk_r) begin
					cnt_nxt = 4'(cnt_r + 4'h1);
					if (cnt_nxt == `LOCK_DCLK_CYCLES) begin
						lk_nxt = LK_IDLE;
					end
				end
			end
			default: lk_nxt = LK_IDLE;
		endcase
	end
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			sh_r   <= 24'h00_0000;
			seen_r <= 5'h00;
			cnt_r  <= 4'h0;
			lk_r   <= LK_IDLE;
			lock_r <= 1'b0;
		end else begin
			sh_r   <= sh_nxt;
			seen_r <= seen_nxt;
			cnt_r  <= cnt_nxt;
			lk_r   <= lk_nxt;
			lock_r <= (lk_nxt == LK_HOLD);
		end
	end
	assign LOCK_O = lock_r;

	// Output buffer; a receiver stall longer than two bits is flagged, the radio cannot wait
	logic buf_ready;
	assign ovf_evt = dclk_r && !buf_ready;
	two_entry_buffer #(.WIDTH(1)) u_buf (
		.clk_i       (CLK_I),
		.rst_n_i     (RST_N_I),
		.in_valid_i  (dclk_r),
		.in_ready_o  (buf_ready),
		.in_data_i   (bit_r),
		.out_valid_o (DATA_VALID_O),
		.out_ready_i (DATA_READY_I),
		.out_data_o  (DATA_O)
	);

	// Checks
	lock_cause_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ6
		$rose(lock_r) |-> $past(hit) && $past(dclk_r)) else $error("lock rose without match");
	lock_release_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ7
		$fell(lock_r) |-> $past(dclk_r) && ($past(cnt_r) == 4'h8))
		else $error("lock fell at wrong count");
	mode_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ8
		hit |-> rx_en && (dmode[2:1] == 2'h1)) else $error("match outside sync modes");
	// Counted apart from the detector's own function, so a broken count still shows
	tol_bound_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ11 RQ15
		hit |-> ($countones((sh_nxt ^ word_r) & ~(24'hFF_FFFF << len)) <= 32'(tol)))
		else $error("too many wrong bits");
	length_map_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ14
		hit |-> seen_nxt >= 5'(12 + 4 * lcode)) else $error("match before full word");
	linear_freeze_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ1
		(dsel != 2'h0) |=> $stable(slice_r) && !dclk_r) else $error("linear path ran");
	slice_thr_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ3
		$changed(slice_r) |-> ((17'($past(avg_r)) > $past(thr)) == slice_r))
		else $error("slice mismatch");
	dclk_tick_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ4
		dclk_r |-> $past(tick) && ($past(ph_r) == `OVS_MID)) else $error("data clock off tick");
	dclk_space_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ13
		dclk_r |=> !dclk_r [*8]) else $error("data clocks too close");
endmodule

// ---- test/fsk_tx_model.sv ----
`timescale 1ns/100ps
module fsk_tx_model #(
	parameter int BIT_CLKS = 32 // Clocks per bit
) (
	input  wire logic clk_i,   // Bench clock
	output logic      lim_i_o, // Limited I sign
	output logic      lim_q_o  // Limited Q sign
);
	logic [1:0] quad_r = 2'h0;

	// Gray coded quadrant, so only one sign flips per step
	assign lim_i_o = quad_r[1];
	assign lim_q_o = quad_r[1] ^ quad_r[0];

	// MSB sent first
	// One bit turns the phasor one way, the other bit the other way; idle holds still
	task automatic send(input logic [23:0] w, input int n);
		for (int b = n - 1; b >= 0; b--) begin
			for (int c = 0; c < BIT_CLKS; c++) begin
				@(posedge clk_i);
				if (c[0])
					quad_r <= w[b] ? quad_r + 2'h1 : quad_r - 2'h1;
			end
		end
	endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
	localparam logic [23:0] WORD = 24'hE14C3B;
	localparam logic [9:0]  BW   = 10'h200;
	localparam logic [23:0] ERR [5] = '{24'h0, 24'h10, 24'h10010, 24'h10810, 24'h410810};

	logic        clk         = 1'b0;
	logic        rst_n       = 1'b0;
	logic        rx_en       = 1'b1;
	logic [7:0]  addr        = 8'h00;
	logic [31:0] wdata       = 32'h0;
	logic        wr_s        = 1'b0;
	logic        rd_s        = 1'b0;
	logic        dready      = 1'b1;
	logic        lim_i;
	logic        lim_q;
	logic [31:0] rdata;
	logic        lock;
	logic        dclk;
	logic        dout;
	logic        dvalid;
	logic [23:0] rx_sh       = 24'h0;
	logic        f_seen;
	logic [23:0] f_cap;
	int          f_held;
	int          f_pulses;
	int          bad_count   = 0;
	int          comparisons = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	// Fast bit rate keeps one bit at 32 clocks
	fsk_sync_word_detector #(.DATA_HZ(781250)) u_dut (
		.CLK_I(clk), .RST_N_I(rst_n), .LIM_I_I(lim_i), .LIM_Q_I(lim_q), .RX_EN_I(rx_en),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
		.LOCK_O(lock), .DCLK_O(dclk), .DATA_O(dout), .DATA_VALID_O(dvalid),
		.DATA_READY_I(dready));

	fsk_tx_model u_tx (.clk_i(clk), .lim_i_o(lim_i), .lim_q_o(lim_q));

	// Bits the receiver accepts, newest in bit 0
	always @(posedge clk)
		if (dvalid && dready)
			rx_sh <= {rx_sh[22:0], dout};

	task automatic chk_bit(input string what, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Read data is taken in the one cycle it stands
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic cfg(input logic [2:0] m, input logic [1:0] s, input logic [9:0] b,
			input logic [1:0] l, input logic [1:0] t);
		wr(8'h00, {6'h00, m, 7'h00, b, s, 4'h0});
		wr(8'h04, {24'h0, t, l, 4'h0});
	endtask

	// Preamble, low n bits of w, then a tail long enough for lock to drop
	task automatic frame(input logic [23:0] w, input int n);
		logic done;
		logic pl;
		logic pd;
		int   k;
		done = 1'b0;
		pl = 1'b0;
		pd = 1'b0;
		k = 0;
		f_seen = 1'b0;
		f_held = 0;
		f_pulses = 0;
		f_cap = 24'h0;
		fork
			begin
				u_tx.send(24'hAAAAAA, 24);
				u_tx.send(24'hAAAAAA, 24);
				u_tx.send(w, n);
				u_tx.send(24'h555555, 16);
				done = 1'b1;
			end
			while (!done) begin
				@(posedge clk);
				#1;
				f_pulses += dclk;
				k = (lock && !f_seen) ? 1 : (k > 0 ? k + 1 : 0);
				f_seen |= lock;
				if (k == 2)
					f_cap = rx_sh;
				if (lock)
					f_held += dclk;
				// A drop not right after a data clock pulse spoils the count
				if (pl && !lock && !pd)
					f_held = -1;
				pl = lock;
				pd = dclk;
			end
		join
	endtask

	task automatic t_regs();
		logic [31:0] d;
		rd(8'h00, d);
		chk_word("demod setup", 32'h0, d);
		rd(8'h04, d);
		chk_word("sync setup", 32'h0, d);
		wr(8'h08, {8'h00, WORD});
		rd(8'h08, d);
		chk_word("sync word", {8'h00, WORD}, d);
		@(posedge clk);
		#1;
		chk_word("read data after", 32'h0, rdata);
		rd(8'h20, d);
		chk_word("unmapped read", 32'h0, d);
		rd(8'h0C, d);
		chk_bit("rx status", 1'b1, d[3]);
		$display("test regs done");
	endtask

	task automatic t_lock();
		cfg(3'h2, 2'h0, BW, 2'h0, 2'h0);
		frame(WORD, 12);
		chk_bit("lock", 1'b1, f_seen);
		chk_word("lock data clocks", 32'h9, 32'(f_held));
		// A frame is 76 bits of 32 clocks; phase nudges may move the count by up to two pulses either way
		chk_bit("data clock", 1'b1, (f_pulses >= 74) && (f_pulses <= 78));
		chk_word("bits", {20'h0, WORD[11:0]}, {20'h0, f_cap[11:0]});
		$display("test lock done");
	endtask

	task automatic t_len();
		for (int c = 0; c < 4; c++) begin
			cfg(3'h3, 2'h0, BW, c[1:0], 2'h0);
			frame(WORD, 12 + 4 * c);
			chk_bit("lock full length", 1'b1, f_seen);
			frame(WORD, 8 + 4 * c);
			chk_bit("lock short length", 1'b0, f_seen);
		end
		$display("test length done");
	endtask

	task automatic t_tol();
		for (int t = 0; t < 4; t++) begin
			cfg(3'h2, 2'h0, BW, 2'h3, t[1:0]);
			frame(WORD ^ ERR[t], 24);
			chk_bit("lock within tolerance", 1'b1, f_seen);
			frame(WORD ^ ERR[t + 1], 24);
			chk_bit("lock past tolerance", 1'b0, f_seen);
		end
		$display("test tolerance done");
	endtask

	task automatic t_gate();
		logic [2:0] modes [3] = '{3'h0, 3'h1, 3'h4};
		foreach (modes[i]) begin
			cfg(modes[i], 2'h0, BW, 2'h0, 2'h0);
			frame(WORD, 12);
			chk_bit("lock other mode", 1'b0, f_seen);
		end
		cfg(3'h2, 2'h0, BW, 2'h0, 2'h0);
		@(posedge clk);
		rx_en <= 1'b0;
		frame(WORD, 12);
		chk_bit("lock out of receive", 1'b0, f_seen);
		@(posedge clk);
		rx_en <= 1'b1;
		cfg(3'h2, 2'h1, BW, 2'h0, 2'h0);
		frame(WORD, 12);
		chk_word("data clocks other path", 32'h0, 32'(f_pulses));
		chk_bit("lock other path", 1'b0, f_seen);
		$display("test gating done");
	endtask

	// Receiver stalls for a whole frame, so the buffer fills and overflows
	task automatic t_buf();
		logic [31:0] d;
		@(posedge clk);
		dready <= 1'b0;
		cfg(3'h2, 2'h0, BW, 2'h0, 2'h0);
		frame(WORD, 12);
		cfg(3'h2, 2'h1, BW, 2'h0, 2'h0);
		rd(8'h0C, d);
		chk_bit("overflow set", 1'b1, d[1]);
		chk_bit("word held", 1'b1, dvalid);
		wr(8'h0C, 32'h0);
		rd(8'h0C, d);
		chk_bit("overflow cleared", 1'b0, d[1]);
		@(posedge clk);
		dready <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk_bit("buffer drained", 1'b0, dvalid);
		$display("test buffer done");
	endtask

	task automatic t_bw();
		logic [31:0] a;
		logic [31:0] b;
		cfg(3'h2, 2'h0, 10'h000, 2'h0, 2'h0);
		rd(8'h10, a);
		frame(WORD, 12);
		rd(8'h10, b);
		chk_word("average frozen", a, b);
		chk_bit("lock frozen filter", 1'b0, f_seen);
		$display("test bandwidth done");
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_lock();
		t_len();
		t_tol();
		t_gate();
		t_buf();
		t_bw();
		report_and_stop();
	end

	// About 24 frames of some 2600 clocks each, with margin
	initial begin
		#3800000;
		bad_count++;
		$display("Error watchdog expected finish seen timeout");
		report_and_stop();
	end
endmodule
